// *** vrtc_cfg.svh ***
`ifndef VRTC_CFG_SVH
`define VRTC_CFG_SVH
`define VRTC_CTRL_OFFSET      8'h00
`define VRTC_CTRL_RESET       8'h00
`define VRTC_BIT_REF_EN       7
`define VRTC_BIT_READY        6
`define VRTC_BIT_TS_EN        5
`define VRTC_BIT_TS_RANGE     4
`define VRTC_CMP_GAIN_HI      3
`define VRTC_CMP_GAIN_LO      2
`define VRTC_ADC_GAIN_HI      1
`define VRTC_ADC_GAIN_LO      0
`define VRTC_SETTLE_NS        1000
`define VRTC_CLK_PERIOD_NS    8
`define VRTC_TEMP_WAIT_US     200
`endif

// *** vrtc_pkg.sv ***
package vrtc_pkg;
    typedef logic [7:0] vrtc_data_t;
    typedef logic [7:0] vrtc_addr_t;
    typedef logic [1:0] vrtc_gain_t;
    typedef enum logic [1:0] {
        VRTC_GAIN_OFF,
        VRTC_GAIN_X1,
        VRTC_GAIN_X2,
        VRTC_GAIN_X4
    } vrtc_gain_e;
    typedef enum {
        VRTC_REF_OFF,
        VRTC_REF_SETTLING,
        VRTC_REF_READY
    } vrtc_ref_state_e;
endpackage

// *** vrtc_voltage_ref_temp_control.sv ***
// Functional notes
// - reference is on exactly while the reference enable bit is one.
// - ready flag stays low after enable until settling time elapses, then sets.
// - on the standard-voltage variant the ready flag always reads one.
// - converter buffer gain field bits 1-0: 11 4x, 10 2x, 01 1x.
// - comparator buffer gain field bits 3-2: same encoding as converter.
// - a cleared gain field switches its buffer off.
// - temperature indicator powered only while sensor enable bit 5 is set.
// - range bit 4 set selects high range, clear selects low range.
// - temperature indicator output routed to a dedicated converter channel.
//
// The address-and-strobe port and the register addresses were decided locally.
`include "vrtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module vrtc_voltage_ref_temp_control #(
    parameter int  SETTLE_CYCLES  = (`VRTC_SETTLE_NS + `VRTC_CLK_PERIOD_NS - 1) / `VRTC_CLK_PERIOD_NS,
    parameter bit  STANDARD_PART  = 1'b0
) (
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    input  wire vrtc_pkg::vrtc_addr_t addr_in,
    input  wire vrtc_pkg::vrtc_data_t wdata_in,
    input  wire logic                 write_in,
    input  wire logic                 read_in,
    output var  vrtc_pkg::vrtc_data_t rdata_out,
    output var  logic                 ref_on_out,
    output var  logic                 ref_ready_out,
    output var  vrtc_pkg::vrtc_gain_t adc_gain_out,
    output var  logic                 adc_buf_on_out,
    output var  vrtc_pkg::vrtc_gain_t cmp_gain_out,
    output var  logic                 cmp_buf_on_out,
    output var  logic                 temp_power_out,
    output var  logic                 temp_high_range_out,
    output var  logic                 temp_to_adc_out
);
    import vrtc_pkg::*;

    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);
    // two extra cycles: one to leave the off state, one for the output flop
    localparam logic [CW:0]   AGE_LIMIT   = (CW+1)'(SETTLE_CYCLES + 2);

    logic            ref_enable_reg;
    logic            temp_sensor_enable_reg;
    logic            temp_sensor_range_reg;
    vrtc_gain_t      comparator_buffer_gain_reg;
    vrtc_gain_t      converter_buffer_gain_reg;
    vrtc_ref_state_e ref_state_reg;
    logic [CW-1:0]   settle_count_reg;
    logic            ready_flag;
    logic            ctrl_hit;
    logic [CW:0]     enabled_age_reg;

    function automatic logic gain_active(input vrtc_gain_t g);
        gain_active = (g != vrtc_gain_t'(VRTC_GAIN_OFF));
    endfunction

    // read word built field by field so the layout follows the bit positions
    function automatic vrtc_data_t ctrl_word(input logic rdy);
        ctrl_word                                        = 8'h00;
        ctrl_word[`VRTC_BIT_REF_EN]                      = ref_enable_reg;
        ctrl_word[`VRTC_BIT_READY]                       = rdy;
        ctrl_word[`VRTC_BIT_TS_EN]                       = temp_sensor_enable_reg;
        ctrl_word[`VRTC_BIT_TS_RANGE]                    = temp_sensor_range_reg;
        ctrl_word[`VRTC_CMP_GAIN_HI:`VRTC_CMP_GAIN_LO]   = comparator_buffer_gain_reg;
        ctrl_word[`VRTC_ADC_GAIN_HI:`VRTC_ADC_GAIN_LO]   = converter_buffer_gain_reg;
    endfunction

    assign ctrl_hit = (addr_in == `VRTC_CTRL_OFFSET);

    // ==========================================================
    // control register writes
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ref_enable_reg             <= 1'b0;
            temp_sensor_enable_reg     <= 1'b0;
            temp_sensor_range_reg      <= 1'b0;
            comparator_buffer_gain_reg <= 2'h0;
            converter_buffer_gain_reg  <= 2'h0;
        end else if (write_in && ctrl_hit) begin
            // ready bit of the write data is dropped
            ref_enable_reg             <= wdata_in[`VRTC_BIT_REF_EN];
            temp_sensor_enable_reg     <= wdata_in[`VRTC_BIT_TS_EN];
            temp_sensor_range_reg      <= wdata_in[`VRTC_BIT_TS_RANGE];
            comparator_buffer_gain_reg <= wdata_in[`VRTC_CMP_GAIN_HI:`VRTC_CMP_GAIN_LO];
            converter_buffer_gain_reg  <= wdata_in[`VRTC_ADC_GAIN_HI:`VRTC_ADC_GAIN_LO];
        end
    end

    // ==========================================================
    // settling sequencer
    // restart on every disable, so a quick off/on never reports a stale ready
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ref_state_reg    <= VRTC_REF_OFF;
            settle_count_reg <= '0;
        end else begin
            case (ref_state_reg)
                VRTC_REF_OFF: begin
                    settle_count_reg <= '0;
                    if (ref_enable_reg) begin
                        ref_state_reg <= VRTC_REF_SETTLING;
                    end
                end
                VRTC_REF_SETTLING: begin
                    if (!ref_enable_reg) begin
                        ref_state_reg <= VRTC_REF_OFF;
                    end else if (settle_count_reg == SETTLE_LAST) begin
                        ref_state_reg <= VRTC_REF_READY;
                    end else begin
                        settle_count_reg <= settle_count_reg + CW'(1);
                    end
                end
                default: begin
                    if (!ref_enable_reg) begin
                        ref_state_reg <= VRTC_REF_OFF;
                    end
                end
            endcase
        end
    end

    assign ready_flag = STANDARD_PART ? 1'b1 : (ref_state_reg == VRTC_REF_READY);

    // ==========================================================
    // assertion helper: cycles since enable, saturating so it never wraps to a false young age
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            enabled_age_reg <= '0;
        end else if (!ref_enable_reg) begin
            enabled_age_reg <= '0;
        end else if (enabled_age_reg != '1) begin
            enabled_age_reg <= enabled_age_reg + (CW+1)'(1);
        end
    end

    // ==========================================================
    // analog control outputs
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ref_on_out          <= 1'b0;
            ref_ready_out       <= 1'b0;
            adc_gain_out        <= 2'h0;
            adc_buf_on_out      <= 1'b0;
            cmp_gain_out        <= 2'h0;
            cmp_buf_on_out      <= 1'b0;
            temp_power_out      <= 1'b0;
            temp_high_range_out <= 1'b0;
            temp_to_adc_out     <= 1'b0;
        end else begin
            ref_on_out          <= ref_enable_reg;
            ref_ready_out       <= ready_flag;
            adc_gain_out        <= converter_buffer_gain_reg;
            adc_buf_on_out      <= gain_active(converter_buffer_gain_reg);
            cmp_gain_out        <= comparator_buffer_gain_reg;
            cmp_buf_on_out      <= gain_active(comparator_buffer_gain_reg);
            temp_power_out      <= temp_sensor_enable_reg;
            temp_high_range_out <= temp_sensor_range_reg;
            // indicator channel only carries a signal while the sensor is powered
            temp_to_adc_out     <= temp_sensor_enable_reg;
        end
    end

    // ==========================================================
    // register read port
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_out <= `VRTC_CTRL_RESET;
        end else if (read_in && ctrl_hit) begin
            rdata_out <= ctrl_word(ready_flag);
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // ==========================================================
    // checks
    ref_follows_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $rose(ref_enable_reg) |=> ref_on_out)
        else $error("reference output did not follow enable");

    ref_level_a: assert property (@(posedge clk_in) disable iff (reset_in)
        ref_on_out == $past(ref_enable_reg))
        else $error("reference output differs from enable");

    ref_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $fell(ref_enable_reg) |=> !ref_on_out)
        else $error("reference output stayed on after disable");

    ready_wait_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (!STANDARD_PART && $rose(ref_enable_reg)) |=> !ref_ready_out [*2])
        else $error("ready rose too early");

    ready_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (!STANDARD_PART && !ref_enable_reg) |-> ##2 !ref_ready_out)
        else $error("ready held while reference off");

    ready_count_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (ref_state_reg == VRTC_REF_SETTLING) |-> (settle_count_reg <= SETTLE_LAST))
        else $error("settling counter ran past its end");

    ready_late_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (!STANDARD_PART && ref_enable_reg && enabled_age_reg == AGE_LIMIT) |-> ref_ready_out)
        else $error("ready not set after settling time");

    ready_read_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (read_in && ctrl_hit) |=> (rdata_out[`VRTC_BIT_READY] == $past(ready_flag)))
        else $error("read word carries wrong ready flag");

    ready_std_a: assert property (@(posedge clk_in) disable iff (reset_in)
        STANDARD_PART |=> ref_ready_out)
        else $error("ready not forced on standard part");

    adc_gain_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (write_in && ctrl_hit) |-> ##2 (adc_gain_out == $past(wdata_in[1:0], 2)))
        else $error("converter gain not applied");

    cmp_gain_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (write_in && ctrl_hit) |-> ##2 (cmp_gain_out == $past(wdata_in[3:2], 2)))
        else $error("comparator gain not applied");

    buf_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (adc_buf_on_out == (adc_gain_out != 2'h0)) && (cmp_buf_on_out == (cmp_gain_out != 2'h0)))
        else $error("buffer power disagrees with gain");

    temp_power_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (write_in && ctrl_hit) |-> ##2 (temp_power_out == $past(wdata_in[5], 2)))
        else $error("sensor power not applied");

    temp_range_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (write_in && ctrl_hit) |-> ##2 (temp_high_range_out == $past(wdata_in[4], 2)))
        else $error("sensor range not applied");

    temp_route_a: assert property (@(posedge clk_in) disable iff (reset_in)
        temp_to_adc_out == temp_power_out)
        else $error("indicator channel differs from sensor power");

    ready_ro_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (write_in && ctrl_hit && !ref_enable_reg && !STANDARD_PART) |=> (ref_state_reg == VRTC_REF_OFF))
        else $error("write disturbed ready flag");
endmodule
`default_nettype wire

// *** test_vrtc_voltage_ref_temp_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_vrtc_voltage_ref_temp_control;
    import vrtc_pkg::*;
    // short settling keeps the run brief; expectations scale from it
    localparam int SETTLE = 4;
    logic        clk_in, reset_in, write_in, read_in, rd_d, live, rdy_exp, std_ready;
    logic        ref_on_out, ref_ready_out, adc_buf_on_out, cmp_buf_on_out;
    logic        temp_power_out, temp_high_range_out, temp_to_adc_out;
    vrtc_addr_t  addr_in;
    vrtc_data_t  wdata_in, rdata_out, shadow;
    vrtc_gain_t  adc_gain_out, cmp_gain_out;
    logic [17:0] exp_q[$];
    logic [17:0] note;
    int          bad_count, total_checks, cycles, seed, n;

    vrtc_voltage_ref_temp_control #(.SETTLE_CYCLES(SETTLE)) dut_u (
        .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
        .read_in(read_in), .rdata_out(rdata_out), .ref_on_out(ref_on_out), .ref_ready_out(ref_ready_out),
        .adc_gain_out(adc_gain_out), .adc_buf_on_out(adc_buf_on_out), .cmp_gain_out(cmp_gain_out),
        .cmp_buf_on_out(cmp_buf_on_out), .temp_power_out(temp_power_out),
        .temp_high_range_out(temp_high_range_out), .temp_to_adc_out(temp_to_adc_out));
    // always-ready variant shares the bus but only its flag is watched
    vrtc_voltage_ref_temp_control #(.SETTLE_CYCLES(SETTLE), .STANDARD_PART(1'h1)) dut_std_u (
        .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
        .read_in(read_in), .rdata_out(), .ref_on_out(), .ref_ready_out(std_ready), .adc_gain_out(),
        .adc_buf_on_out(), .cmp_gain_out(), .cmp_buf_on_out(), .temp_power_out(),
        .temp_high_range_out(), .temp_to_adc_out());

    // ========================================
    // helpers
    function automatic logic [17:0] exp_of(input vrtc_data_t v, input logic rdy, input logic hit);
        exp_of = {hit ? {v[7], rdy, v[5:0]} : 8'h00, v[7], v[1:0], |v[1:0], v[3:2], |v[3:2], v[5], v[4], v[5]};
    endfunction
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'h1) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic bus(input logic w, input logic r, input vrtc_addr_t a, input vrtc_data_t d);
        @(posedge clk_in);
        write_in <= w;
        read_in <= r;
        addr_in <= a;
        wdata_in <= d;
        if (w && a == 8'h00) shadow = d;
        if (r) exp_q.push_back(exp_of(shadow, rdy_exp, a == 8'h00));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ========================================
    // clock, monitor and timeout
    initial begin
        clk_in = 1'h0;
        forever #4 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        rd_d <= read_in & ~reset_in;
        live <= ~reset_in;
        if (live) check(std_ready === 1'h1, "standard part not ready");
        if (rd_d) begin
            note = exp_q.pop_front();
            check({rdata_out, ref_on_out, adc_gain_out, adc_buf_on_out, cmp_gain_out, cmp_buf_on_out,
                   temp_power_out, temp_high_range_out, temp_to_adc_out} === note, "read or outputs");
        end
        cycles++;
        if (cycles > 2000) begin
            bad_count++;
            $display("mismatch at %0t: timeout", $time);
            conclude();
        end
    end

    // ========================================
    // main sequence
    initial begin
        seed = 32'h8E0D;
        {reset_in, write_in, read_in, rd_d, live, rdy_exp} = 6'h20;
        addr_in = 8'h00;
        wdata_in = 8'h00;
        shadow = 8'h00;
        repeat (10) @(posedge clk_in);
        reset_in <= 1'h0;
        bus(1'h0, 1'h1, 8'h00, 8'h00);
        $display("test reset value done");
        bus(1'h1, 1'h0, 8'h00, 8'h80);
        bus(1'h0, 1'h0, 8'h00, 8'h00);
        n = 0;
        while (ref_ready_out !== 1'h1 && n < 50) begin
            @(posedge clk_in);
            n++;
        end
        check(n >= SETTLE && n <= SETTLE + 6, "ready settle time");
        rdy_exp = 1'h1;
        bus(1'h0, 1'h1, 8'h00, 8'h00);
        $display("test settling done");
        // every gain code on both fields, random sensor bits and a random ready bit written
        for (int i = 0; i < 32; i++) begin
            bus(1'h1, 1'h0, 8'h00, 8'h80 | (8'($random(seed)) & 8'h70) | 8'(i % 16));
            bus(1'h0, 1'h1, 8'h00, 8'h00);
        end
        $display("test field sweep done");
        bus(1'h1, 1'h0, 8'h01, 8'hFF);
        bus(1'h0, 1'h1, 8'h05, 8'h00);
        bus(1'h0, 1'h1, 8'h00, 8'h00);
        $display("test unmapped done");
        // sensor goes on here and the reference goes off; the idle waits let ready drop and the last read drain
        bus(1'h1, 1'h0, 8'h00, 8'h3C);
        rdy_exp = 1'h0;
        repeat (3) bus(1'h0, 1'h0, 8'h00, 8'h00);
        bus(1'h0, 1'h1, 8'h00, 8'h00);
        bus(1'h1, 1'h0, 8'h00, 8'h00);
        bus(1'h0, 1'h1, 8'h00, 8'h00);
        repeat (3) bus(1'h0, 1'h0, 8'h00, 8'h00);
        check(exp_q.size() == 0, "reads left unanswered");
        $display("test disable done");
        conclude();
    end
endmodule
`default_nettype wire
